// ### rtl/vectored_interrupt_and_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Seven maskable sources, each its own vector
// - Twelve-bit timer counts up at 1 MHz
// - Periodic 128 us and 1.024 ms interrupts
// - Endpoint interrupt after its transaction completes
// - Per-pin mask gates the shared GPIO interrupt
// - Per-pin polarity picks rising or falling edge
// - Timer count readable anytime for interval measurement
// - PS/2 mode raises interrupt on line activity
module vectored_interrupt_and_tick_timer (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [vic_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        usb_bus_reset,
	input  wire logic [vic_pkg::EP_N-1:0]    ep_done,
	input  wire logic                        wake_tick,
	input  wire logic [vic_pkg::GPIO_N-1:0]  gpio_pin,
	input  wire logic                        ps2_clk_pin,
	input  wire logic                        ps2_data_pin,
	input  wire logic                        irq_ack,
	output logic                             irq,
	output logic      [vic_pkg::VEC_W-1:0]   irq_vector
);

	tick_if tk ();

	logic [vic_pkg::NUM_SRC-1:0] status_r;
	logic [vic_pkg::NUM_SRC-1:0] enable_r;
	logic [vic_pkg::NUM_SRC-1:0] event_v;
	logic [vic_pkg::NUM_SRC-1:0] clear_v;
	logic [vic_pkg::NUM_SRC-1:0] pend_v;
	logic [vic_pkg::GPIO_N-1:0]  gpio_en_r;
	logic [vic_pkg::GPIO_N-1:0]  gpio_pol_r;
	logic [vic_pkg::GPIO_N-1:0]  gpio_m_r;
	logic [vic_pkg::GPIO_N-1:0]  gpio_s_r;
	logic [vic_pkg::GPIO_N-1:0]  gpio_d_r;
	logic [vic_pkg::GPIO_N-1:0]  gpio_hit;
	logic [1:0]                  ps2_m_r;
	logic [1:0]                  ps2_s_r;
	logic                        ps2_mode_r;
	vic_pkg::ps2_state_t         ps2_state_r;
	logic [6:0]                  ps2_quiet_r;
	logic                        ps2_start;
	logic [vic_pkg::VEC_W-1:0]   vector_r;
	logic [31:0]                 prdata_r;
	logic                        pslverr_r;
	logic                        apb_setup;
	logic                        apb_write;
	logic                        ack_hit;

	tick_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk)
	);

	// Lowest pending vector wins
	function automatic logic [vic_pkg::VEC_W-1:0] lowest_vec(input logic [vic_pkg::NUM_SRC-1:0] p);
		logic [vic_pkg::VEC_W-1:0] v;
		v = '0;
		for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				v = vic_pkg::VEC_W'(i);
			end
		end
		return v;
	endfunction

	// Address decode used for the error answer; read data has its own case
	function automatic logic addr_mapped(input logic [vic_pkg::ADDR_W-1:0] a);
		logic ok;
		ok = 1'b0;
		unique case (a)
			vic_pkg::OFF_TIMER, vic_pkg::OFF_STATUS, vic_pkg::OFF_CLEAR,
			vic_pkg::OFF_ENABLE, vic_pkg::OFF_GPIO_EN, vic_pkg::OFF_GPIO_POL,
			vic_pkg::OFF_CTRL, vic_pkg::OFF_VECTOR: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// APB phases; slave always ready
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign pready    = 1'b1;

	// Two-flop synchronisers for pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio_m_r <= '0;
			gpio_s_r <= '0;
			gpio_d_r <= '0;
			ps2_m_r  <= 2'h3;
			ps2_s_r  <= 2'h3;
		end else begin
			gpio_m_r <= gpio_pin;
			gpio_s_r <= gpio_m_r;
			gpio_d_r <= gpio_s_r;
			ps2_m_r  <= {ps2_clk_pin, ps2_data_pin};
			ps2_s_r  <= ps2_m_r;
		end
	end

	// Per-pin edge select and mask
	for (genvar g = 0; g < vic_pkg::GPIO_N; g++) begin : g_pin
		assign gpio_hit[g] = gpio_en_r[g] &&
			(gpio_pol_r[g] ? (gpio_s_r[g] && !gpio_d_r[g]) : (!gpio_s_r[g] && gpio_d_r[g]));
	end

	// PS/2 activity detector, re-armed after quiet lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps2_state_r <= vic_pkg::PS2_ARMED;
			ps2_quiet_r <= '0;
		end else begin
			unique case (ps2_state_r)
				vic_pkg::PS2_ARMED: begin
					ps2_quiet_r <= '0;
					if (ps2_start) begin
						ps2_state_r <= vic_pkg::PS2_BUSY;
					end
				end
				vic_pkg::PS2_BUSY: begin
					if (!ps2_mode_r) begin
						ps2_state_r <= vic_pkg::PS2_ARMED;
					end else if (ps2_s_r != 2'h3) begin
						ps2_quiet_r <= '0;
					end else if (tk.tick_us) begin
						if (ps2_quiet_r == vic_pkg::PS2_IDLE_LAST) begin
							ps2_state_r <= vic_pkg::PS2_ARMED;
						end else begin
							ps2_quiet_r <= ps2_quiet_r + 7'h01;
						end
					end
				end
			endcase
		end
	end

	assign ps2_start = ps2_mode_r && (ps2_state_r == vic_pkg::PS2_ARMED) && (ps2_s_r != 2'h3);

	// Source events, one bit per vector
	always_comb begin
		event_v = '0;
		event_v[vic_pkg::SRC_BUS_RST]  = usb_bus_reset || ps2_start;
		event_v[vic_pkg::SRC_TICK128]  = tk.tap128;
		event_v[vic_pkg::SRC_TICK1024] = tk.tap1024;
		event_v[vic_pkg::SRC_EP0]      = ep_done[0];
		event_v[vic_pkg::SRC_EP1]      = ep_done[1];
		event_v[vic_pkg::SRC_WAKE]     = wake_tick;
		event_v[vic_pkg::SRC_GPIO]     = |gpio_hit;
	end

	// Clears from software and from the CPU acknowledge
	assign ack_hit = irq_ack && status_r[vector_r];
	always_comb begin
		clear_v = '0;
		if (apb_write && paddr == vic_pkg::OFF_CLEAR) begin
			clear_v = pwdata[vic_pkg::NUM_SRC-1:0];
		end
		if (ack_hit) begin
			clear_v[vector_r] = 1'b1;
		end
	end

	// Sticky status; a new event beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~clear_v) | event_v;
		end
	end

	// Masked pending set and vector register
	assign pend_v = status_r & enable_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_r <= '0;
		end else begin
			vector_r <= lowest_vec(pend_v);
		end
	end

	assign irq        = |pend_v;
	assign irq_vector = vector_r;

	// Software-written control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r   <= vic_pkg::ENABLE_RST;
			gpio_en_r  <= vic_pkg::GPIO_EN_RST;
			gpio_pol_r <= vic_pkg::GPIO_POL_RST;
			ps2_mode_r <= 1'b0;
		end else if (apb_write) begin
			unique case (paddr)
				vic_pkg::OFF_ENABLE:   enable_r   <= pwdata[vic_pkg::NUM_SRC-1:0];
				vic_pkg::OFF_GPIO_EN:  gpio_en_r  <= pwdata[vic_pkg::GPIO_N-1:0];
				vic_pkg::OFF_GPIO_POL: gpio_pol_r <= pwdata[vic_pkg::GPIO_N-1:0];
				vic_pkg::OFF_CTRL:     ps2_mode_r <= pwdata[vic_pkg::CTRL_PS2_BIT];
				default: ;
			endcase
		end
	end

	// Read data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else if (apb_setup) begin
			pslverr_r <= !addr_mapped(paddr);
			prdata_r  <= '0;
			unique case (paddr)
				vic_pkg::OFF_TIMER:    prdata_r[vic_pkg::TIMER_W-1:0] <= tk.count;
				vic_pkg::OFF_STATUS:   prdata_r[vic_pkg::NUM_SRC-1:0] <= status_r;
				vic_pkg::OFF_ENABLE:   prdata_r[vic_pkg::NUM_SRC-1:0] <= enable_r;
				vic_pkg::OFF_GPIO_EN:  prdata_r[vic_pkg::GPIO_N-1:0]  <= gpio_en_r;
				vic_pkg::OFF_GPIO_POL: prdata_r[vic_pkg::GPIO_N-1:0]  <= gpio_pol_r;
				vic_pkg::OFF_CTRL:     prdata_r[vic_pkg::CTRL_PS2_BIT] <= ps2_mode_r;
				vic_pkg::OFF_VECTOR:   prdata_r[vic_pkg::VEC_IRQ_BIT:0] <= {irq, vector_r};
				default: ;
			endcase
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	// Checks

	sequence s_timer_read;
		apb_setup && !pwrite && paddr == vic_pkg::OFF_TIMER;
	endsequence

	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(|event_v) |=> ((status_r & $past(event_v)) == $past(event_v)))
		else $error("event lost against a clear");

	a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(ack_hit && !event_v[vector_r]) |=> !status_r[$past(vector_r)])
		else $error("acknowledge did not clear the served bit");

	a_pending_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(status_r[vic_pkg::SRC_WAKE] && !irq_ack && !apb_write) |=> status_r[vic_pkg::SRC_WAKE])
		else $error("pending bit dropped without a clear");

	a_vector_lowest: assert property (@(posedge pclk) disable iff (!presetn)
		(pend_v[0] && $past(pend_v[0])) |-> irq_vector == '0)
		else $error("vector 0 pending but not served first");

	a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
		(event_v[vic_pkg::SRC_EP0] && enable_r[vic_pkg::SRC_EP0] && !apb_write) |=> irq)
		else $error("enabled endpoint event gave no interrupt");

	a_gpio_masked: assert property (@(posedge pclk) disable iff (!presetn)
		(gpio_en_r == '0) |-> !event_v[vic_pkg::SRC_GPIO])
		else $error("masked pins raised the GPIO event");

	a_gpio_rise: assert property (@(posedge pclk) disable iff (!presetn)
		(gpio_en_r[0] && gpio_pol_r[0] && $rose(gpio_s_r[0])) |=> status_r[vic_pkg::SRC_GPIO])
		else $error("rising edge on pin 0 not caught");

	a_ps2_start: assert property (@(posedge pclk) disable iff (!presetn)
		ps2_start |=> status_r[vic_pkg::SRC_BUS_RST] && ps2_state_r == vic_pkg::PS2_BUSY)
		else $error("PS/2 activity did not raise the interrupt");

	a_timer_read: assert property (@(posedge pclk) disable iff (!presetn)
		s_timer_read |=> prdata[vic_pkg::TIMER_W-1:0] == $past(tk.count) && !pslverr)
		else $error("timer read returned a stale count");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_setup && !addr_mapped(paddr)) |=> pslverr && prdata == '0)
		else $error("unmapped address not answered with an error");

	sequence s_status_read;
		apb_setup && !pwrite && paddr == vic_pkg::OFF_STATUS;
	endsequence

	a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
		s_status_read |=> prdata[vic_pkg::NUM_SRC-1:0] == $past(status_r) && !pslverr)
		else $error("status read returned a stale value");

	a_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_write && paddr == vic_pkg::OFF_CLEAR && pwdata[vic_pkg::SRC_WAKE] && !event_v[vic_pkg::SRC_WAKE]) |=> !status_r[vic_pkg::SRC_WAKE])
		else $error("clear write left the wake bit set");

	a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_write && paddr == vic_pkg::OFF_ENABLE) |=> enable_r == $past(pwdata[vic_pkg::NUM_SRC-1:0]))
		else $error("enable write did not land");

	a_vector_pending: assert property (@(posedge pclk) disable iff (!presetn)
		(irq && $past(irq) && $stable(pend_v)) |-> pend_v[irq_vector])
		else $error("vector points at a source that is not pending");

	a_tick_sets: assert property (@(posedge pclk) disable iff (!presetn)
		tk.tap128 |=> status_r[vic_pkg::SRC_TICK128])
		else $error("128 us tick did not set its status");

	a_slow_tick_sets: assert property (@(posedge pclk) disable iff (!presetn)
		tk.tap1024 |=> status_r[vic_pkg::SRC_TICK1024])
		else $error("1.024 ms tick did not set its status");

	a_ep1_sets: assert property (@(posedge pclk) disable iff (!presetn)
		ep_done[1] |=> status_r[vic_pkg::SRC_EP1])
		else $error("endpoint 1 completion did not set its status");

	a_wake_sets: assert property (@(posedge pclk) disable iff (!presetn)
		wake_tick |=> status_r[vic_pkg::SRC_WAKE])
		else $error("wake tick did not set its status");

	a_gpio_fall: assert property (@(posedge pclk) disable iff (!presetn)
		(gpio_en_r[0] && !gpio_pol_r[0] && $fell(gpio_s_r[0])) |=> status_r[vic_pkg::SRC_GPIO])
		else $error("falling edge on pin 0 not caught");

	a_ps2_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(ps2_state_r == vic_pkg::PS2_BUSY && ps2_mode_r && ps2_s_r != 2'h3) |=> ps2_quiet_r == '0)
		else $error("line activity did not restart the quiet count");

	a_ps2_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
		(!ps2_mode_r && ps2_state_r == vic_pkg::PS2_BUSY) |=> ps2_state_r == vic_pkg::PS2_ARMED)
		else $error("detector stayed busy with PS/2 mode off");

endmodule

`default_nettype wire

// ### pkg/vic_pkg.sv
package vic_pkg;

	// Clock and timer rates
	localparam int unsigned CLK_HZ   = 125_000_000;
	localparam int unsigned TICK_HZ  = 1_000_000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int unsigned DIV_W    = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

	// Free-running timer shape
	localparam int unsigned TIMER_W  = 12;
	localparam int unsigned TAP_128  = 7;
	localparam int unsigned TAP_1024 = 10;

	// Interrupt sources, index equals vector number
	localparam int unsigned NUM_SRC      = 7;
	localparam int unsigned VEC_W        = 3;
	localparam int unsigned SRC_BUS_RST  = 0;
	localparam int unsigned SRC_TICK128  = 1;
	localparam int unsigned SRC_TICK1024 = 2;
	localparam int unsigned SRC_EP0      = 3;
	localparam int unsigned SRC_EP1      = 4;
	localparam int unsigned SRC_WAKE     = 5;
	localparam int unsigned SRC_GPIO     = 6;
	localparam int unsigned EP_N         = 2;
	localparam int unsigned GPIO_N       = 10;

	// APB register byte offsets
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_TIMER    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CLEAR    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ENABLE   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_GPIO_EN  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_GPIO_POL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_VECTOR   = 8'h1c;

	// Reset values and field positions
	localparam logic [NUM_SRC-1:0] ENABLE_RST   = 7'h00;
	localparam logic [GPIO_N-1:0]  GPIO_EN_RST  = 10'h000;
	localparam logic [GPIO_N-1:0]  GPIO_POL_RST = 10'h000;
	localparam int unsigned CTRL_PS2_BIT   = 0;
	localparam int unsigned VEC_IRQ_BIT    = 3;

	// Quiet time that re-arms the PS/2 activity detector
	localparam int unsigned PS2_IDLE_US = 100;
	localparam int unsigned PS2_IDLE_TICKS = PS2_IDLE_US * TICK_HZ / 1_000_000;
	localparam logic [6:0] PS2_IDLE_LAST = 7'(PS2_IDLE_TICKS - 1);

	typedef enum logic [0:0] {PS2_ARMED, PS2_BUSY} ps2_state_t;

endpackage

// ### pkg/tick_if.sv
`timescale 1ns/1ps
`default_nettype none

// Timer count and tick enables shared between timer and controller
interface tick_if;
	logic [vic_pkg::TIMER_W-1:0] count;
	logic                        tick_us;
	logic                        tap128;
	logic                        tap1024;

	modport timer (output count, output tick_us, output tap128, output tap1024);
	modport user  (input count, input tick_us, input tap128, input tap1024);
endinterface

`default_nettype wire

// ### rtl/tick_timer.sv
`timescale 1ns/1ps
`default_nettype none

module tick_timer (
	input  wire logic pclk,
	input  wire logic presetn,
	tick_if.timer     tk
);

	logic [vic_pkg::DIV_W-1:0]   div_r;
	logic [vic_pkg::TIMER_W-1:0] cnt_r;
	logic [vic_pkg::TIMER_W-1:0] cnt_nxt;
	logic                        us_r;
	logic                        t128_r;
	logic                        t1024_r;
	logic                        us_en;

	assign us_en   = (div_r == vic_pkg::DIV_LAST);
	assign cnt_nxt = cnt_r + 12'h001;

	// Prescaler down to a 1 MHz enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= '0;
		end else if (us_en) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 7'h01;
		end
	end

	// Free-running count, never reloaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (us_en) begin
			cnt_r <= cnt_nxt;
		end
	end

	// One-cycle pulses on each flip of the tap bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_r    <= 1'b0;
			t128_r  <= 1'b0;
			t1024_r <= 1'b0;
		end else begin
			us_r    <= us_en;
			t128_r  <= us_en && (cnt_nxt[vic_pkg::TAP_128] != cnt_r[vic_pkg::TAP_128]);
			t1024_r <= us_en && (cnt_nxt[vic_pkg::TAP_1024] != cnt_r[vic_pkg::TAP_1024]);
		end
	end

	assign tk.count   = cnt_r;
	assign tk.tick_us = us_r;
	assign tk.tap128  = t128_r;
	assign tk.tap1024 = t1024_r;

	a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		us_en |=> cnt_r == $past(cnt_r) + 12'h001)
		else $error("timer did not advance on its enable");

	a_tap_aligned: assert property (@(posedge pclk) disable iff (!presetn)
		t128_r |-> cnt_r[6:0] == 7'h00 && $past(us_en))
		else $error("128 us tap off the counter boundary");

	a_slow_tap_aligned: assert property (@(posedge pclk) disable iff (!presetn)
		t1024_r |-> cnt_r[9:0] == 10'h000 && $past(us_en))
		else $error("1.024 ms tap off the counter boundary");

endmodule

`default_nettype wire

// ### sim/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// CPU side: takes the pending vector and acknowledges it
module cpu_model (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      en,
	input  wire logic                      irq,
	input  wire logic [vic_pkg::VEC_W-1:0] vec,
	output logic                           ack,
	output logic      [8:0]                served
);
	logic [1:0] wait_r;

	// Two cycles of settling for the registered vector, then a one-cycle ack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack    <= 1'b0;
			wait_r <= 2'd0;
			served <= 9'h000;
		end else begin
			ack <= 1'b0;
			if (en && irq && !ack && wait_r == 2'd2) begin
				ack    <= 1'b1;
				served <= {served[5:0], vec};
				wait_r <= 2'd0;
			end else if (en && irq && !ack) begin
				wait_r <= wait_r + 2'd1;
			end
		end
	end
endmodule

`default_nettype wire

// ### sim/vectored_interrupt_and_tick_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_and_tick_timer_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        usb_bus_reset;
	logic [1:0]  ep_done;
	logic        wake_tick;
	logic [9:0]  gpio_pin;
	logic        ps2_clk_pin;
	logic        ps2_data_pin;
	logic        irq_ack;
	logic        irq;
	logic [2:0]  irq_vector;
	logic        cpu_en;
	logic [8:0]  served;
	int          fail_count;
	int          n_checks;
	logic [31:0] q;
	logic        err;

	vectored_interrupt_and_tick_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_bus_reset(usb_bus_reset), .ep_done(ep_done), .wake_tick(wake_tick), .gpio_pin(gpio_pin),
		.ps2_clk_pin(ps2_clk_pin), .ps2_data_pin(ps2_data_pin), .irq_ack(irq_ack), .irq(irq),
		.irq_vector(irq_vector));

	cpu_model cpu (.pclk(pclk), .presetn(presetn), .en(cpu_en), .irq(irq), .vec(irq_vector),
		.ack(irq_ack), .served(served));

	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			chk("pready", 1, 0);
			summarize();
		end else begin
			q = prdata;
			err = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	// Bounded wait for an irq level
	task automatic wait_irq(input logic lvl, input int lim);
		int n;
		n = 0;
		while (irq !== lvl && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (irq !== lvl) begin
			chk("irq wait", lvl, irq);
			summarize();
		end
	endtask

	// Read a status bit after letting a stimulus settle
	task automatic stat_bit(input int b, input logic e, input string nm);
		repeat (6) @(posedge pclk);
		apb(1'b0, vic_pkg::OFF_STATUS, 0);
		chk(nm, e, q[b]);
	endtask

	// Reset values and an unmapped address
	task automatic t_reset();
		apb(1'b0, vic_pkg::OFF_ENABLE, 0);
		chk("enable", 0, q);
		apb(1'b0, vic_pkg::OFF_GPIO_EN, 0);
		chk("gpio_en", 0, q);
		apb(1'b0, vic_pkg::OFF_GPIO_POL, 0);
		chk("gpio_pol", 0, q);
		apb(1'b0, vic_pkg::OFF_STATUS, 0);
		chk("status", 0, q);
		apb(1'b0, 8'h20, 0);
		chk("unmapped err", 1, err);
	endtask

	// Masked bus reset, then three events served lowest first
	task automatic t_prio();
		usb_bus_reset <= 1'b1;
		@(posedge pclk);
		usb_bus_reset <= 1'b0;
		stat_bit(0, 1'b1, "bus reset status");
		chk("masked irq", 0, irq);
		apb(1'b1, vic_pkg::OFF_CLEAR, 32'h7f);
		apb(1'b1, vic_pkg::OFF_ENABLE, 32'h79);
		ep_done   <= 2'b11;
		wake_tick <= 1'b1;
		@(posedge pclk);
		ep_done   <= 2'b00;
		wake_tick <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, vic_pkg::OFF_STATUS, 0);
		chk("pending", 32'h38, q & 32'h79);
		apb(1'b0, vic_pkg::OFF_VECTOR, 0);
		chk("vector", 32'h0b, q);
		cpu_en <= 1'b1;
		@(posedge pclk);
		wait_irq(1'b0, 60);
		chk("order", {3'd3, 3'd4, 3'd5}, served);
		cpu_en <= 1'b0;
		apb(1'b1, vic_pkg::OFF_ENABLE, 0);
	endtask

	// Per-pin mask and polarity
	task automatic t_gpio();
		logic [9:0] pv[4];
		logic       ex[4];
		pv = '{10'h006, 10'h007, 10'h003, 10'h002};
		ex = '{1'b0, 1'b1, 1'b1, 1'b0};
		apb(1'b1, vic_pkg::OFF_GPIO_EN, 32'h005);
		apb(1'b1, vic_pkg::OFF_GPIO_POL, 32'h001);
		apb(1'b1, vic_pkg::OFF_CLEAR, 32'h7f);
		for (int i = 0; i < 4; i++) begin
			gpio_pin <= pv[i];
			stat_bit(6, ex[i], "gpio status");
			apb(1'b1, vic_pkg::OFF_CLEAR, 32'h40);
		end
	endtask

	// Line activity flags only in PS/2 mode
	task automatic t_ps2();
		apb(1'b1, vic_pkg::OFF_CLEAR, 32'h7f);
		ps2_clk_pin <= 1'b0;
		stat_bit(0, 1'b0, "ps2 off");
		apb(1'b1, vic_pkg::OFF_CTRL, 32'h1);
		stat_bit(0, 1'b1, "ps2 start");
		ps2_clk_pin <= 1'b1;
		apb(1'b1, vic_pkg::OFF_CTRL, 0);
	endtask

	// Two readings 1250 cycles apart differ by ten counts
	task automatic t_timer();
		logic [31:0] q1;
		apb(1'b0, vic_pkg::OFF_TIMER, 0);
		q1 = q;
		repeat (1247) @(posedge pclk);
		apb(1'b0, vic_pkg::OFF_TIMER, 0);
		chk("timer step", 10, (q - q1) & 32'hfff);
	endtask

	// Tick period of 128 counts
	task automatic t_tick();
		longint t1;
		apb(1'b1, vic_pkg::OFF_ENABLE, 32'h02);
		cpu_en <= 1'b1;
		wait_irq(1'b1, 17000);
		t1 = $time;
		wait_irq(1'b0, 20);
		wait_irq(1'b1, 17000);
		chk("tick period", 16000, ($time - t1) / 8);
		chk("tick vector", 1, served[2:0]);
		cpu_en <= 1'b0;
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		usb_bus_reset = 1'b0;
		ep_done = 2'b00;
		wake_tick = 1'b0;
		gpio_pin = 10'h004;
		ps2_clk_pin = 1'b1;
		ps2_data_pin = 1'b1;
		cpu_en = 1'b0;
		fail_count = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_prio();
		t_gpio();
		t_ps2();
		t_timer();
		t_tick();
		summarize();
	end
endmodule

`default_nettype wire
